//--- rtl/mss_defines.vh
// constants for the multi-segment stage sequencer
`ifndef MSS_DEFINES_VH
`define MSS_DEFINES_VH
// register word addresses
`define MSS_A_SP_BASE    6'h00
`define MSS_A_DUR_BASE   6'h10
`define MSS_A_RAMP_BASE  6'h20
`define MSS_A_END_MODE   6'h30
`define MSS_A_RETAIN     6'h31
`define MSS_A_CTRL       6'h32
`define MSS_A_MAX_FREQ   6'h33
`define MSS_A_STATUS     6'h34
`define MSS_A_ELAPSED    6'h35
// set-point limits in 0.1 percent units
`define MSS_SP_MAX       16'sh03e8
`define MSS_SP_MIN       -16'sh03e8
`define MSS_SP_RST       16'h0000
`define MSS_SP_DIV       34'sh0000003e8
// end-of-cycle modes
`define MSS_END_STOP     2'h0
`define MSS_END_HOLD     2'h1
`define MSS_END_LOOP     2'h2
// field positions
`define MSS_RET_PWR_BIT  0
`define MSS_RET_STOP_BIT 4
`define MSS_CTRL_SEQ_BIT 0
`define MSS_CTRL_LAST_LO 4
`define MSS_CTRL_LAST_HI 7
// reset values
`define MSS_DUR_RST      16'h0000
`define MSS_RAMP_RST     2'h0
`define MSS_LAST_RST     4'hf
`define MSS_MAXF_RST     16'h1388
// duration tick: 0.1 s at 25 MHz
`define MSS_TICK_NS      100000000
`define MSS_CLK_NS       40
`endif

//--- rtl/mss_top.v
// multi-segment set-points and timed stage sequencer for a drive
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "mss_defines.vh"
module mss_top #(
   parameter TICK_CYC = `MSS_TICK_NS / `MSS_CLK_NS
) (
   input  wire               core_clk,
   input  wire               rst_b,
   input  wire [5:0]         reg_addr,
   input  wire [15:0]        reg_wdata,
   input  wire               reg_wr,
   input  wire               reg_rd,
   output reg  [15:0]        reg_rdata,
   input  wire [3:0]         di_segment_sel,
   input  wire               run_req,
   input  wire               stop_req,
   input  wire               power_loss,
   output reg                running_q,
   output reg                holding_q,
   output reg  [3:0]         stage_q,
   output reg  [1:0]         ramp_set_q,
   output reg                cycle_done_q,
   output reg  signed [16:0] freq_ref_q,
   output reg  signed [15:0] vf_ref_q,
   output reg  signed [15:0] pid_ref_q
);

   localparam ST_IDLE = 2'h0;
   localparam ST_RUN  = 2'h1;
   localparam ST_HOLD = 2'h2;

   integer i;

   reg signed [15:0] sp_q   [0:15];
   reg [15:0]        dur_q  [0:15];
   reg [1:0]         ramp_q [0:15];
   reg [1:0]         end_mode_q;
   reg               ret_pwr_q;
   reg               ret_stop_q;
   reg               seq_en_q;
   reg [3:0]         last_stage_q;
   reg [15:0]        max_freq_q;
   reg [1:0]         state_q;
   reg [1:0]         state_d;
   reg [3:0]         stage_d;
   reg [15:0]        elapsed_q;
   reg [15:0]        elapsed_d;
   reg [31:0]        presc_q;
   reg               done_d;

   wire signed [15:0] wr_sp;
   wire               wr_sp_hi;
   wire               wr_sp_lo;
   wire               tick;
   wire [15:0]        dur_cur;
   wire               stage_end;
   wire signed [15:0] di_sp;
   wire signed [15:0] seq_sp;
   wire signed [33:0] freq_prod;
   wire signed [33:0] freq_quot;

   // clamp written set-point into the legal percentage span
   assign wr_sp    = reg_wdata;
   assign wr_sp_hi = wr_sp > `MSS_SP_MAX;
   assign wr_sp_lo = wr_sp < `MSS_SP_MIN;

   // configuration registers, written over the plain port
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (i = 0; i < 16; i = i + 1) begin
            sp_q[i]   <= `MSS_SP_RST;
            dur_q[i]  <= `MSS_DUR_RST;
            ramp_q[i] <= `MSS_RAMP_RST;
         end
         end_mode_q   <= `MSS_END_STOP;
         ret_pwr_q    <= 1'b0;
         ret_stop_q   <= 1'b0;
         seq_en_q     <= 1'b0;
         last_stage_q <= `MSS_LAST_RST;
         max_freq_q   <= `MSS_MAXF_RST;
      end else if (reg_wr) begin
         case (reg_addr[5:4])
            2'h0: begin
               if (wr_sp_hi) begin
                  sp_q[reg_addr[3:0]] <= `MSS_SP_MAX;
               end else if (wr_sp_lo) begin
                  sp_q[reg_addr[3:0]] <= `MSS_SP_MIN;
               end else begin
                  sp_q[reg_addr[3:0]] <= wr_sp;
               end
            end
            2'h1: begin
               dur_q[reg_addr[3:0]] <= reg_wdata;
            end
            2'h2: begin
               ramp_q[reg_addr[3:0]] <= reg_wdata[1:0];
            end
            default: begin
               if (reg_addr == `MSS_A_END_MODE) begin
                  if (reg_wdata[1:0] == 2'h3) begin
                     end_mode_q <= `MSS_END_LOOP;
                  end else begin
                     end_mode_q <= reg_wdata[1:0];
                  end
               end
               if (reg_addr == `MSS_A_RETAIN) begin
                  ret_pwr_q  <= reg_wdata[`MSS_RET_PWR_BIT];
                  ret_stop_q <= reg_wdata[`MSS_RET_STOP_BIT];
               end
               if (reg_addr == `MSS_A_CTRL) begin
                  seq_en_q     <= reg_wdata[`MSS_CTRL_SEQ_BIT];
                  last_stage_q <= reg_wdata[`MSS_CTRL_LAST_HI:
                                            `MSS_CTRL_LAST_LO];
               end
               if (reg_addr == `MSS_A_MAX_FREQ) begin
                  max_freq_q <= reg_wdata;
               end
            end
         endcase
      end
   end

   // read data stands one cycle after the strobe; unmapped reads zero
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr[5:4])
            2'h0: reg_rdata <= sp_q[reg_addr[3:0]];
            2'h1: reg_rdata <= dur_q[reg_addr[3:0]];
            2'h2: reg_rdata <= {14'h0000, ramp_q[reg_addr[3:0]]};
            default: begin
               case (reg_addr)
                  `MSS_A_END_MODE: reg_rdata <= {14'h0000, end_mode_q};
                  `MSS_A_RETAIN:
                     reg_rdata <= {11'h000, ret_stop_q, 3'h0, ret_pwr_q};
                  `MSS_A_CTRL:
                     reg_rdata <= {8'h00, last_stage_q, 3'h0, seq_en_q};
                  `MSS_A_MAX_FREQ: reg_rdata <= max_freq_q;
                  `MSS_A_STATUS:
                     reg_rdata <= {8'h00, stage_q, ramp_set_q,
                                   holding_q, running_q};
                  `MSS_A_ELAPSED:  reg_rdata <= elapsed_q;
                  default:         reg_rdata <= 16'h0000;
               endcase
            end
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // tenth-unit prescaler; restarts on each stage so timing is exact
   assign tick = (presc_q == TICK_CYC - 1);

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         presc_q <= 32'h00000000;
      end else if (state_q != ST_RUN || stage_end || tick) begin
         presc_q <= 32'h00000000;
      end else begin
         presc_q <= presc_q + 32'h00000001;
      end
   end

   // a zero duration stage is passed through in one cycle
   assign dur_cur   = dur_q[stage_q];
   assign stage_end = (elapsed_q >= dur_cur);

   // sequencer next state
   always @* begin
      state_d   = state_q;
      stage_d   = stage_q;
      elapsed_d = elapsed_q;
      done_d    = 1'b0;
      case (state_q)
         ST_IDLE: begin
            // run resumes from saved stage and time
            if (run_req && !stop_req) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (stop_req) begin
               state_d = ST_IDLE;
            end else if (stage_end) begin
               elapsed_d = 16'h0000;
               if (stage_q >= last_stage_q) begin
                  done_d = 1'b1;
                  case (end_mode_q)
                     `MSS_END_STOP: begin
                        state_d = ST_IDLE;
                        stage_d = 4'h0;
                     end
                     `MSS_END_HOLD: begin
                        state_d = ST_HOLD;
                     end
                     default: begin
                        stage_d = 4'h0;
                     end
                  endcase
               end else begin
                  stage_d = stage_q + 4'h1;
               end
            end else if (tick) begin
               elapsed_d = elapsed_q + 16'h0001;
            end
         end
         ST_HOLD: begin
            if (stop_req) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      // a stop without retention restarts next run
      if (stop_req && state_q != ST_IDLE && !ret_stop_q) begin
         stage_d   = 4'h0;
         elapsed_d = 16'h0000;
      end
      // power loss forgets position unless retained
      if (power_loss) begin
         state_d = ST_IDLE;
         if (!ret_pwr_q) begin
            stage_d   = 4'h0;
            elapsed_d = 16'h0000;
         end
      end
   end

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q      <= ST_IDLE;
         stage_q      <= 4'h0;
         elapsed_q    <= 16'h0000;
         cycle_done_q <= 1'b0;
      end else begin
         state_q      <= state_d;
         stage_q      <= stage_d;
         elapsed_q    <= elapsed_d;
         cycle_done_q <= done_d;
      end
   end

   assign di_sp  = sp_q[di_segment_sel];
   assign seq_sp = seq_en_q ? sp_q[stage_d] : di_sp;

   // scale by maximum frequency; divide keeps sign toward zero
   assign freq_prod = seq_sp * $signed({18'h00000, max_freq_q});
   assign freq_quot = freq_prod / `MSS_SP_DIV;

   // outputs registered; frequency is zero whenever not running
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         running_q  <= 1'b0;
         holding_q  <= 1'b0;
         ramp_set_q <= `MSS_RAMP_RST;
         freq_ref_q <= 17'sh00000;
         vf_ref_q   <= 16'sh0000;
         pid_ref_q  <= 16'sh0000;
      end else begin
         running_q  <= (state_d != ST_IDLE);
         holding_q  <= (state_d == ST_HOLD);
         ramp_set_q <= ramp_q[stage_d];
         if (state_d != ST_IDLE) begin
            freq_ref_q <= freq_quot[16:0];
         end else begin
            freq_ref_q <= 17'sh00000;
         end
         vf_ref_q   <= di_sp;
         pid_ref_q  <= di_sp;
      end
   end

endmodule

//--- tb/mss_props.sv
// port checker for the stage sequencer
`timescale 1ns/1ns
module mss_props (
   input wire               core_clk,
   input wire               rst_b,
   input wire               reg_rd,
   input wire [15:0]        reg_rdata,
   input wire               run_req,
   input wire               stop_req,
   input wire               power_loss,
   input wire               running_q,
   input wire               holding_q,
   input wire               cycle_done_q,
   input wire signed [16:0] freq_ref_q,
   input wire signed [15:0] vf_ref_q,
   input wire signed [15:0] pid_ref_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // read data only stands in the cycle after a read
   property p_rd_gap; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
   property p_go;
      !running_q && run_req && !stop_req && !power_loss |=> running_q;
   endproperty
   property p_stop; running_q && stop_req |=> !running_q; endproperty
   property p_pwr; power_loss |=> !running_q; endproperty
   // a looping zero-length last stage may legally pulse every cycle,
   // so the one-cycle check is made where the pass ends in a stop
   property p_done;
      cycle_done_q && !running_q |=> !cycle_done_q;
   endproperty
   property p_hold; holding_q |-> running_q; endproperty
   // the output register is zero from the first idle cycle; the check starts one cycle later
   property p_idle_f;
      !running_q && !$past(running_q) |-> freq_ref_q == 17'sh00000;
   endproperty
   property p_pid; pid_ref_q == vf_ref_q; endproperty
   property p_lim; pid_ref_q <= 16'sd1000 && pid_ref_q >= -16'sd1000;
   endproperty
   a_rd_gap: assert property (p_rd_gap) else $error("stray read data");
   a_go: assert property (p_go) else $error("run not taken");
   a_stop: assert property (p_stop) else $error("stop not taken");
   a_pwr: assert property (p_pwr) else $error("power loss kept run");
   a_done: assert property (p_done) else $error("done too long");
   a_hold: assert property (p_hold) else $error("hold while idle");
   a_idle_f: assert property (p_idle_f) else $error("idle freq");
   a_pid: assert property (p_pid) else $error("pid and vf differ");
   a_lim: assert property (p_lim) else $error("set-point range");
   c_go: cover property (!running_q ##1 running_q);
   c_done: cover property (cycle_done_q);
   c_hold: cover property (holding_q);
endmodule
bind mss_top mss_props i_mss_props (.*);

//--- tb/mss_ctl_model.sv
// drive run and stop command logic facing the sequencer
`timescale 1ns/1ns
module mss_ctl_model (
   input wire core_clk,
   input wire rst_b,
   input wire start,
   input wire halt,
   output reg run_req,
   output reg stop_req
);
   // one-cycle commands
   // registered so commands leave just after an edge, as real logic does
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         run_req  <= 1'b0;
         stop_req <= 1'b0;
      end else begin
         run_req  <= start;
         stop_req <= halt;
      end
   end
endmodule

//--- tb/mss_top_tb.sv
// self-checking bench for the stage sequencer
`timescale 1ns/1ns
module mss_top_tb;
   localparam TICK = 4;
   reg                core_clk, rst_b, reg_wr, reg_rd, power_loss;
   reg                start, halt;
   reg         [5:0]  reg_addr;
   reg         [15:0] reg_wdata;
   reg         [3:0]  di_segment_sel;
   reg         [31:0] seed;
   reg  signed [15:0] v;
   reg  signed [15:0] sp [0:15];
   wire        [15:0] reg_rdata;
   wire               run_req, stop_req, running_q, holding_q, cycle_done_q;
   wire        [3:0]  stage_q;
   wire        [1:0]  ramp_set_q;
   wire signed [16:0] freq_ref_q;
   wire signed [15:0] vf_ref_q, pid_ref_q;
   integer            num_errors, comparisons, cyc, i, k, n;
   mss_top #(.TICK_CYC(TICK)) i_mss_top (.*);
   mss_ctl_model i_mss_ctl_model (.*);
   initial core_clk = 1'b0;
   always #20 core_clk = ~core_clk;
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function signed [15:0] clamp(input signed [15:0] x);
      clamp = x > 1000 ? 16'sd1000 : (x < -1000 ? -16'sd1000 : x);
   endfunction
   task chk(input [16:0] got, input [16:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr(input [5:0] a, input [15:0] d);
      begin
         @(posedge core_clk);
         reg_addr  <= a;
         reg_wdata <= d;
         reg_wr    <= 1'b1;
         @(posedge core_clk);
         reg_wr    <= 1'b0;
      end
   endtask
   task rd(input [5:0] a, input [15:0] exp);
      begin
         @(posedge core_clk);
         reg_addr <= a;
         reg_rd   <= 1'b1;
         @(posedge core_clk);
         reg_rd   <= 1'b0;
         #1 chk(reg_rdata, exp);
      end
   endtask
   // 0 run, 1 stop, 2 power loss, each one cycle long
   task cmd(input [1:0] w);
      begin
         @(posedge core_clk);
         {power_loss, halt, start} <= 3'b001 << w;
         @(posedge core_clk);
         {power_loss, halt, start} <= 3'b000;
      end
   endtask
   task until_run(input x);
      begin
         n = 0;
         while (running_q !== x && n < 99) begin
            @(posedge core_clk);
            #1 n = n + 1;
         end
         chk(running_q, x);
      end
   endtask
   task end_of_test;
      begin
         if (num_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         end_of_test;
      end
   end
   initial begin
      {rst_b, reg_wr, reg_rd, power_loss, start, halt} = 6'h00;
      {reg_addr, reg_wdata, di_segment_sel} = 26'h0000000;
      seed = 32'hdfed;
      {num_errors, comparisons, cyc} = 96'h0;
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(6'h0f, 16'h0000);
      rd(6'h10, 16'h0000);
      rd(6'h24, 16'h0000);
      rd(6'h30, 16'h0000);
      rd(6'h32, 16'h00f0);
      rd(6'h3f, 16'h0000);
      // random set-points near the limits, then picked by input code
      for (i = 0; i < 16; i = i + 1) begin
         seed = lfsr(seed);
         v = i == 0 ? 16'sh7fff : {{5{seed[10]}}, seed[10:0]};
         wr(i[5:0], v);
         di_segment_sel <= i[3:0];
         sp[i] = clamp(v);
         rd(i[5:0], sp[i]);
         repeat (3) @(posedge core_clk);
         #1 chk(pid_ref_q, sp[i]);
         chk(vf_ref_q, sp[i]);
      end
      for (k = 0; k < 3; k = k + 1) begin
         wr(k[5:0] + 6'h10, k[15:0] + 16'h1);
         wr(k[5:0] + 6'h20, k[15:0] + 16'h1);
      end
      wr(6'h32, 16'h0021);
      // one pass through three stages in every end mode
      for (i = 0; i < 3; i = i + 1) begin
         wr(6'h30, i[15:0]);
         cmd(2'd0);
         until_run(1'b1);
         for (k = 0; k < 3; k = k + 1) begin
            n = 0;
            while (stage_q === k[3:0] && holding_q === 1'b0 &&
                   running_q === 1'b1 && n < 99) begin
               @(posedge core_clk);
               #1 n = n + 1;
               if (n == 1) begin
                  chk(ramp_set_q, k[1:0] + 2'h1);
                  chk(freq_ref_q, sp[k] * 5000 / 1000);
               end
            end
            chk(n, k * TICK + TICK + 1);
         end
         if (i == 0)
            chk(cycle_done_q, 1'b1);
         chk(running_q, i != 0);
         chk(holding_q, i == 1);
         chk(stage_q, i == 1 ? 4'h2 : 4'h0);
         cmd(2'd1);
         until_run(1'b0);
      end
      // the unused end mode code falls back to looping
      wr(6'h30, 16'h0003);
      rd(6'h30, 16'h0002);
      // resume point after a stop or a power loss
      for (i = 0; i < 4; i = i + 1) begin
         wr(6'h31, (i == 1 || i == 2) ? 16'h0001 : 16'h0010);
         rd(6'h31, (i == 1 || i == 2) ? 16'h0001 : 16'h0010);
         cmd(2'd0);
         n = 0;
         while (stage_q !== 4'h1 && n < 99) begin
            @(posedge core_clk);
            #1 n = n + 1;
         end
         cmd(i[0] ? 2'd2 : 2'd1);
         cmd(2'd0);
         until_run(1'b1);
         chk(stage_q, i < 2 ? 4'h1 : 4'h0);
         cmd(2'd1);
         until_run(1'b0);
      end
      end_of_test;
   end
endmodule
